// >>> drfm_datapath.sv
// general register set and operation datapath of the fixed-point core
`timescale 1ns/10ps
module drfm_datapath (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // operation request from the sequencer
    input wire logic op_valid,
    input wire drfm_pkg::drfm_op_t op_code,
    input wire logic [2:0] op_dst,
    input wire logic [2:0] op_src_a,
    input wire logic [2:0] op_src_b,
    input wire logic op_use_imm,
    input wire logic [15:0] op_imm,
    // load from x/y data bus
    input wire logic ld_valid,
    input wire logic [2:0] ld_reg,
    input wire drfm_pkg::drfm_part_t ld_part,
    input wire logic [15:0] ld_data,
    // store to x/y data bus
    input wire logic [2:0] st_reg,
    input wire drfm_pkg::drfm_part_t st_part,
    output logic [15:0] st_data,
    // inter-register transfer
    input wire logic mv_valid,
    input wire logic [2:0] mv_src,
    input wire logic [2:0] mv_dst,
    input wire drfm_pkg::drfm_part_t mv_part,
    // operation result
    output logic res_valid,
    output logic [39:0] res_data,
    output logic res_ovf32
);
    import drfm_pkg::*;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    function automatic drfm_unit_t unit_of(input drfm_op_t op);
        case (op)
            OP_NOP: unit_of = UNIT_NONE;
            OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_EXPONENT: unit_of = UNIT_ALU;
            OP_SHIFT_LEFT, OP_SHIFT_RIGHT: unit_of = UNIT_SHIFT;
            default: unit_of = UNIT_MAC;
        endcase
    endfunction : unit_of

    // replace only the selected part of a register
    function automatic logic [39:0] merge_part(input logic [39:0] old,
                                               input drfm_part_t part,
                                               input logic [39:0] val);
        case (part)
            PART_LOW: merge_part = {old[39:16], val[15:0]};
            PART_HIGH: merge_part = {old[39:32], val[31:16], old[15:0]};
            PART_EXT: merge_part = {val[39:32], old[31:0]};
            default: merge_part = val;
        endcase
    endfunction : merge_part

    // ---------------------------------------------------------------
    // register set and operand read
    // ---------------------------------------------------------------
    logic [39:0] gpr [0:7];
    logic [39:0] opnd_a;
    logic [39:0] opnd_b;
    logic [39:0] opnd_d;
    logic [39:0] ld_word;
    drfm_unit_t unit;
    logic op_write;
    logic [39:0] next_result;
    logic [39:0] alu_result;
    logic [39:0] shift_result;
    logic [5:0] exp_count;
    logic [5:0] shamt;

    assign opnd_a = gpr[op_src_a];
    // immediate sits in bits 15..0, upper bits zero
    assign opnd_b = op_use_imm ? {24'h00_0000, op_imm} : gpr[op_src_b];
    assign opnd_d = gpr[op_dst];
    assign unit = op_valid ? unit_of(op_code) : UNIT_NONE;
    assign op_write = unit != UNIT_NONE;

    // ---------------------------------------------------------------
    // multiply-accumulator
    // ---------------------------------------------------------------
    drfm_mac_if mac_if ();

    always_comb
    begin
        mac_if.acc = opnd_d;
        mac_if.opa = opnd_a[31:16];
        mac_if.opb = opnd_b[31:16];
        mac_if.mode = MAC_IDLE;
        if (unit == UNIT_MAC)
        begin
            case (op_code)
                OP_PLAIN_MULTIPLY: mac_if.mode = MAC_MPY;
                OP_SIGNED_MULTIPLY_ADD: mac_if.mode = MAC_ADD_SS;
                OP_SIGNED_MULTIPLY_SUBTRACT: mac_if.mode = MAC_SUB_SS;
                OP_SIGNED_UNSIGNED_MULTIPLY_ADD:
                begin
                    mac_if.mode = MAC_ADD_SU;
                    mac_if.opb = opnd_b[15:0];
                end
                OP_UNSIGNED_UNSIGNED_MULTIPLY_ADD:
                begin
                    mac_if.mode = MAC_ADD_UU;
                    mac_if.opa = opnd_a[15:0];
                    mac_if.opb = opnd_b[15:0];
                end
                OP_SHIFT_ONE_MULTIPLY_ADD: mac_if.mode = MAC_ADD_SH1;
                OP_SHIFT_SIXTEEN_MULTIPLY_ADD: mac_if.mode = MAC_ADD_SH16;
                default: mac_if.mode = MAC_IDLE;
            endcase
        end
    end

    drfm_mac u_mac (
        .mac (mac_if.unit)
    );

    // ---------------------------------------------------------------
    // arithmetic and logic unit, barrel shift unit
    // ---------------------------------------------------------------
    // redundant sign bits of the 32-bit fixed-point value
    always_comb
    begin
        exp_count = 6'h00;
        for (int i = 30; i >= 0; i--)
        begin
            if (opnd_a[i] == opnd_a[DRFM_POINT_BIT] && exp_count == 6'(30 - i))
            begin
                exp_count = 6'(31 - i);
            end
        end
    end

    always_comb
    begin
        case (op_code)
            OP_ADD: alu_result = opnd_a + opnd_b;
            OP_SUB: alu_result = opnd_a - opnd_b;
            OP_AND: alu_result = opnd_a & opnd_b;
            OP_OR: alu_result = opnd_a | opnd_b;
            OP_XOR: alu_result = opnd_a ^ opnd_b;
            OP_EXPONENT: alu_result = {34'h0_0000_0000, exp_count};
            default: alu_result = opnd_a;
        endcase
    end

    // shift amount is a 16-bit integer in the low part
    assign shamt = (opnd_b[15:0] > 16'h0028) ? 6'h28 : opnd_b[5:0];

    always_comb
    begin
        case (op_code)
            OP_SHIFT_LEFT: shift_result = opnd_a << shamt;
            OP_SHIFT_RIGHT: shift_result = 40'($signed(opnd_a) >>> shamt);
            default: shift_result = opnd_a;
        endcase
    end

    always_comb
    begin
        case (unit)
            UNIT_MAC: next_result = mac_if.result;
            UNIT_ALU: next_result = alu_result;
            UNIT_SHIFT: next_result = shift_result;
            default: next_result = opnd_d;
        endcase
    end

    // ---------------------------------------------------------------
    // register writes: operation, then transfer, then load
    // ---------------------------------------------------------------
    always_comb
    begin
        case (ld_part)
            PART_LOW: ld_word = {24'h00_0000, ld_data};
            PART_HIGH: ld_word = {8'h00, ld_data, 16'h0000};
            PART_EXT: ld_word = {ld_data[7:0], 32'h0000_0000};
            default: ld_word = {{8{ld_data[15]}}, ld_data, 16'h0000};
        endcase
    end

    for (genvar g = 0; g < DRFM_REG_COUNT; g++)
    begin : g_reg
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                gpr[g] <= DRFM_REG_RESET;
            end
            else if (op_write && op_dst == 3'(g))
            begin
                gpr[g] <= next_result;
            end
            else if (mv_valid && mv_dst == 3'(g))
            begin
                gpr[g] <= merge_part(gpr[g], mv_part, gpr[mv_src]);
            end
            else if (ld_valid && ld_reg == 3'(g))
            begin
                gpr[g] <= merge_part(gpr[g], ld_part, ld_word);
            end
        end
    end

    // ---------------------------------------------------------------
    // store read and result outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_data <= 16'h0000;
        end
        else
        begin
            case (st_part)
                PART_LOW: st_data <= gpr[st_reg][15:0];
                PART_EXT: st_data <= {8'h00, gpr[st_reg][39:32]};
                default: st_data <= gpr[st_reg][31:16];
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            res_valid <= 1'b0;
            res_data <= DRFM_REG_RESET;
            res_ovf32 <= 1'b0;
        end
        else
        begin
            res_valid <= op_write;
            if (op_write)
            begin
                res_data <= next_result;
                // extension differs from the 32-bit sign
                res_ovf32 <= next_result[39:32] != {8{next_result[DRFM_POINT_BIT]}};
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [39:0] chk_sum;
    logic [39:0] chk_sh16;
    logic [39:16] chk_ld_upper;
    logic chk_ld_alone;

    assign chk_sum = opnd_a + opnd_b;
    assign chk_sh16 = {{16{opnd_d[39]}}, opnd_d[39:16]};
    assign chk_ld_upper = gpr[ld_reg][39:16];
    assign chk_ld_alone = ld_valid && ld_part == PART_LOW
        && !(op_write && op_dst == ld_reg) && !(mv_valid && mv_dst == ld_reg);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_reg_written: assert property (op_write |=> gpr[$past(op_dst)] == res_data)
        else $error("operation result not written to destination");
    a_low_only: assert property (chk_ld_alone |=> gpr[$past(ld_reg)][39:16] == $past(chk_ld_upper))
        else $error("low part load disturbed upper parts");
    a_imm_zero: assert property (op_valid && op_use_imm |-> opnd_b[39:16] == 24'h00_0000)
        else $error("immediate not zero extended");
    a_add_carry: assert property (op_valid && op_code == OP_ADD |=> res_data == $past(chk_sum))
        else $error("40-bit add result wrong");
    a_minus_one: assert property (op_valid && op_code == OP_PLAIN_MULTIPLY
        && opnd_a[31:16] == DRFM_MINUS_ONE && opnd_b[31:16] == DRFM_MINUS_ONE
        |=> res_data == DRFM_PLUS_ONE ##0 res_ovf32)
        else $error("minus one squared wrong");
    a_mpy_lsb: assert property (op_valid && op_code == OP_PLAIN_MULTIPLY |=> !res_data[0])
        else $error("signed product lsb not zero");
    a_sh16_zero: assert property (op_valid && op_code == OP_SHIFT_SIXTEEN_MULTIPLY_ADD
        && opnd_a[31:16] == 16'h0000 |=> res_data == $past(chk_sh16))
        else $error("accumulator not shifted by sixteen");
    a_one_unit: assert property ($onehot0({mac_if.mode != MAC_IDLE,
        unit == UNIT_ALU, unit == UNIT_SHIFT}))
        else $error("more than one unit active");
    a_su_only: assert property (mac_if.mode == MAC_ADD_SU
        |-> op_valid && op_code == OP_SIGNED_UNSIGNED_MULTIPLY_ADD)
        else $error("signed-unsigned multiply outside its instruction");
    a_store_ext: assert property (st_part == PART_EXT |=> st_data[15:8] == 8'h00)
        else $error("extension store upper byte not zero");
    a_result_pulse: assert property (!op_valid |=> !res_valid)
        else $error("result valid without operation");

    // ---------------------------------------------------------------
    // store, transfer, flag, product extension and exponent range checks
    // ---------------------------------------------------------------
    a_ext_sign: assert property (op_valid && op_code == OP_PLAIN_MULTIPLY
        |=> res_data[39:32] == {8{res_data[32]}})
        else $error("product not sign extended into extension part");
    a_store_low: assert property (st_part == PART_LOW
        |=> st_data == $past(gpr[st_reg][15:0]))
        else $error("low part store wrong");
    a_store_high: assert property (st_part == PART_HIGH
        |=> st_data == $past(gpr[st_reg][31:16]))
        else $error("high part store wrong");
    a_move_full: assert property (mv_valid && mv_part == PART_FULL
        && !(op_write && op_dst == mv_dst) |=> gpr[$past(mv_dst)] == $past(gpr[mv_src]))
        else $error("full transfer did not copy the source");
    a_ovf_flag: assert property (res_valid
        |-> res_ovf32 == (res_data[39:32] != {8{res_data[DRFM_POINT_BIT]}}))
        else $error("32-bit overflow flag wrong");
    a_exp_range: assert property (op_valid && op_code == OP_EXPONENT
        |=> res_data[39:5] == 35'h0)
        else $error("exponent count out of range");

    c_minus_one: cover property (op_valid && op_code == OP_PLAIN_MULTIPLY
        && opnd_a[31:16] == DRFM_MINUS_ONE && opnd_b[31:16] == DRFM_MINUS_ONE);
    c_shift_sixteen_multiply_add: cover property (op_valid && op_code == OP_SHIFT_SIXTEEN_MULTIPLY_ADD);
    c_load_move: cover property (ld_valid ##1 mv_valid);
    c_overflow: cover property (res_valid && res_ovf32);
    c_shift_one: cover property (op_valid && op_code == OP_SHIFT_ONE_MULTIPLY_ADD);

endmodule : drfm_datapath

// >>> drfm_pkg.sv
// constants and types shared by the register file and multiply-accumulator
package drfm_pkg;

    // ---------------------------------------------------------------
    // widths and field positions
    // ---------------------------------------------------------------
    localparam int DRFM_WIDTH = 40;
    localparam int DRFM_REG_COUNT = 8;
    localparam int DRFM_SEL_W = 3;
    localparam int DRFM_HALF_W = 16;
    localparam int DRFM_EXT_W = 8;
    localparam int DRFM_LOW_MSB = 15;
    localparam int DRFM_HIGH_LSB = 16;
    localparam int DRFM_HIGH_MSB = 31;
    localparam int DRFM_EXT_LSB = 32;
    localparam int DRFM_EXT_MSB = 39;
    localparam int DRFM_POINT_BIT = 31;
    localparam int DRFM_SHAMT_W = 6;
    localparam int DRFM_EXP_W = 6;

    // ---------------------------------------------------------------
    // reset and fixed values
    // ---------------------------------------------------------------
    localparam logic [39:0] DRFM_REG_RESET = 40'h00_0000_0000;
    localparam logic [15:0] DRFM_MINUS_ONE = 16'h8000;
    localparam logic [39:0] DRFM_PLUS_ONE = 40'h00_8000_0000;

    // ---------------------------------------------------------------
    // operations, register parts, units, accumulator modes
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_PLAIN_MULTIPLY = 4'h1,
        OP_SIGNED_MULTIPLY_ADD = 4'h2,
        OP_SIGNED_MULTIPLY_SUBTRACT = 4'h3,
        OP_SIGNED_UNSIGNED_MULTIPLY_ADD = 4'h4,
        OP_UNSIGNED_UNSIGNED_MULTIPLY_ADD = 4'h5,
        OP_SHIFT_ONE_MULTIPLY_ADD = 4'h6,
        OP_SHIFT_SIXTEEN_MULTIPLY_ADD = 4'h7,
        OP_ADD = 4'h8,
        OP_SUB = 4'h9,
        OP_AND = 4'hA,
        OP_OR = 4'hB,
        OP_XOR = 4'hC,
        OP_EXPONENT = 4'hD,
        OP_SHIFT_LEFT = 4'hE,
        OP_SHIFT_RIGHT = 4'hF
    } drfm_op_t;

    typedef enum logic [1:0] {
        PART_LOW = 2'h0,
        PART_HIGH = 2'h1,
        PART_EXT = 2'h2,
        PART_FULL = 2'h3
    } drfm_part_t;

    typedef enum logic [1:0] {
        UNIT_NONE = 2'h0,
        UNIT_MAC = 2'h1,
        UNIT_ALU = 2'h2,
        UNIT_SHIFT = 2'h3
    } drfm_unit_t;

    typedef enum logic [2:0] {
        MAC_IDLE = 3'h0,
        MAC_MPY = 3'h1,
        MAC_ADD_SS = 3'h2,
        MAC_SUB_SS = 3'h3,
        MAC_ADD_SU = 3'h4,
        MAC_ADD_UU = 3'h5,
        MAC_ADD_SH1 = 3'h6,
        MAC_ADD_SH16 = 3'h7
    } drfm_mac_mode_t;

endpackage : drfm_pkg

// >>> drfm_mac_if.sv
// signals between the operand router and the multiply-accumulator
`timescale 1ns/10ps
interface drfm_mac_if;
    import drfm_pkg::*;
    logic [39:0] acc;
    logic [15:0] opa;
    logic [15:0] opb;
    drfm_mac_mode_t mode;
    logic [39:0] result;
    modport core (output acc, output opa, output opb, output mode, input result);
    modport unit (input acc, input opa, input opb, input mode, output result);
endinterface : drfm_mac_if

// >>> drfm_mac.sv
// multiply-accumulator with accumulator input shifter
`timescale 1ns/10ps
module drfm_mac (
    // operands and result
    drfm_mac_if.unit mac
);
    import drfm_pkg::*;

    // ---------------------------------------------------------------
    // products
    // ---------------------------------------------------------------
    logic signed [31:0] ss_raw;
    logic signed [32:0] su_raw;
    logic [31:0] uu_raw;
    logic [39:0] prod_ss;
    logic [39:0] prod_su;
    logic [39:0] prod_uu;
    logic [39:0] acc_sh1;
    logic [39:0] acc_sh16;

    assign ss_raw = $signed(mac.opa) * $signed(mac.opb);
    // binary point between bits 31 and 30, lsb always zero
    assign prod_ss = {{7{ss_raw[31]}}, ss_raw, 1'b0};
    assign su_raw = $signed(mac.opa) * $signed({1'b0, mac.opb});
    assign prod_su = {{7{su_raw[32]}}, su_raw};
    assign uu_raw = mac.opa * mac.opb;
    assign prod_uu = {8'h00, uu_raw};

    // accumulator input shifter, arithmetic
    assign acc_sh1 = {mac.acc[39], mac.acc[39:1]};
    assign acc_sh16 = {{16{mac.acc[39]}}, mac.acc[39:16]};

    // ---------------------------------------------------------------
    // accumulate
    // ---------------------------------------------------------------
    always_comb
    begin
        case (mac.mode)
            MAC_MPY: mac.result = prod_ss;
            MAC_ADD_SS: mac.result = mac.acc + prod_ss;
            MAC_SUB_SS: mac.result = mac.acc - prod_ss;
            MAC_ADD_SU: mac.result = mac.acc + prod_su;
            MAC_ADD_UU: mac.result = mac.acc + prod_uu;
            MAC_ADD_SH1: mac.result = acc_sh1 + prod_ss;
            MAC_ADD_SH16: mac.result = acc_sh16 + prod_ss;
            default: mac.result = mac.acc;
        endcase
    end

endmodule : drfm_mac

// >>> drfm_xy_mem.sv
// x/y data memory model that supplies load words to the datapath
`timescale 1ns/10ps
module drfm_xy_mem (
    // clock
    input wire logic clk,
    // preload port
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [15:0] wr_data,
    // load read port
    input wire logic [2:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [8];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // asynchronous read, the bus word is valid in the cycle of the load
    assign rd_data = mem[rd_addr];
endmodule : drfm_xy_mem

// >>> tb_drfm_datapath.sv
// self-checking testbench of the register set and multiply-accumulate datapath
`timescale 1ns/10ps
module tb_drfm_datapath;
    import drfm_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk, sys_rst, op_valid, op_use_imm, ld_valid, mv_valid, wr_en;
    drfm_op_t op_code;
    logic [2:0] op_dst, op_src_a, op_src_b, ld_reg, st_reg, mv_src, mv_dst, wr_addr, rd_addr;
    logic [15:0] op_imm, wr_data, ld_data, st_data;
    drfm_part_t ld_part, st_part, mv_part;
    logic res_valid, res_ovf32;
    logic [39:0] res_data;
    int mismatches = 0;
    int cmp_count = 0;

    drfm_datapath i_drfm_datapath (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .op_dst(op_dst), .op_src_a(op_src_a), .op_src_b(op_src_b),
        .op_use_imm(op_use_imm), .op_imm(op_imm), .ld_valid(ld_valid), .ld_reg(ld_reg),
        .ld_part(ld_part), .ld_data(ld_data), .st_reg(st_reg), .st_part(st_part),
        .st_data(st_data), .mv_valid(mv_valid), .mv_src(mv_src), .mv_dst(mv_dst),
        .mv_part(mv_part), .res_valid(res_valid), .res_data(res_data), .res_ovf32(res_ovf32));

    drfm_xy_mem i_drfm_xy_mem (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(ld_data));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    function automatic logic ovf(input logic [39:0] v);
        return v[39:32] != {8{v[31]}};
    endfunction : ovf

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic mem_put(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : mem_put

    task automatic ld(input logic [2:0] r, input drfm_part_t p, input logic [2:0] a);
        @(posedge clk);
        ld_valid <= 1'b1;
        ld_reg <= r;
        ld_part <= p;
        rd_addr <= a;
        @(posedge clk);
        ld_valid <= 1'b0;
    endtask : ld

    task automatic mv(input logic [2:0] s, input logic [2:0] d, input drfm_part_t p);
        @(posedge clk);
        mv_valid <= 1'b1;
        mv_src <= s;
        mv_dst <= d;
        mv_part <= p;
        @(posedge clk);
        mv_valid <= 1'b0;
    endtask : mv

    task automatic st(input logic [2:0] r, input drfm_part_t p, input logic [15:0] exp);
        @(posedge clk);
        st_reg <= r;
        st_part <= p;
        @(posedge clk);
        #1;
        chk({26'h0, st_data}, {26'h0, exp});
    endtask : st

    task automatic put_op(input drfm_op_t c, input logic [2:0] d, input logic [2:0] a,
                          input logic [2:0] b, input logic u, input logic [15:0] imm);
        op_valid <= 1'b1;
        op_code <= c;
        op_dst <= d;
        op_src_a <= a;
        op_src_b <= b;
        op_use_imm <= u;
        op_imm <= imm;
    endtask : put_op

    task automatic op(input drfm_op_t c, input logic [2:0] d, input logic [2:0] a,
                      input logic [2:0] b, input logic u, input logic [15:0] imm,
                      input logic [39:0] exp);
        @(posedge clk);
        put_op(c, d, a, b, u, imm);
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk({res_valid, res_ovf32, res_data}, {1'b1, ovf(exp), exp});
    endtask : op

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_parts();
        ld(3'h3, PART_HIGH, 3'h0);
        ld(3'h3, PART_LOW, 3'h1);
        ld(3'h3, PART_EXT, 3'h2);
        st(3'h3, PART_LOW, 16'hABCD);
        st(3'h3, PART_HIGH, 16'h1234);
        st(3'h3, PART_EXT, 16'h00A5);
        ld(3'h2, PART_FULL, 3'h1);
        st(3'h2, PART_EXT, 16'h00FF);
        st(3'h2, PART_LOW, 16'h0000);
        op(OP_OR, 3'h4, 3'h3, 3'h0, 1'b1, 16'h0000, 40'hA5_1234_ABCD);
    endtask : t_parts

    task automatic t_alu();
        drfm_op_t codes [8] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_EXPONENT,
                                OP_SHIFT_LEFT, OP_SHIFT_RIGHT};
        logic [15:0] imms [8] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
                                  16'h0000, 16'h0004, 16'h0004};
        logic [39:0] exps [8] = '{40'hA5_1235_ABCC, 40'hA5_1234_AACE, 40'h00_0000_00CD,
                                  40'hA5_1234_ABFF, 40'hA5_1234_AB32, 40'h00_0000_0002,
                                  40'h51_234A_BCD0, 40'hFA_5123_4ABC};
        for (int i = 0; i < 8; i++)
        begin
            op(codes[i], 3'h7, 3'h3, 3'h0, 1'b1, imms[i], exps[i]);
        end
    endtask : t_alu

    task automatic t_multiply();
        ld(3'h1, PART_FULL, 3'h3);
        ld(3'h1, PART_LOW, 3'h1);
        ld(3'h2, PART_FULL, 3'h3);
        ld(3'h4, PART_FULL, 3'h4);
        ld(3'h5, PART_FULL, 3'h5);
        ld(3'h6, PART_LOW, 3'h7);
        op(OP_PLAIN_MULTIPLY, 3'h0, 3'h1, 3'h2, 1'b0, 16'h0000, 40'h00_8000_0000);
        op(OP_PLAIN_MULTIPLY, 3'h7, 3'h4, 3'h5, 1'b0, 16'h0000, 40'hFF_E000_0000);
    endtask : t_multiply

    task automatic t_accumulate();
        op(OP_SIGNED_MULTIPLY_ADD, 3'h0, 3'h1, 3'h2, 1'b0, 16'h0000, 40'h01_0000_0000);
        op(OP_SIGNED_MULTIPLY_SUBTRACT, 3'h0, 3'h4, 3'h5, 1'b0, 16'h0000,
           40'h01_2000_0000);
        op(OP_SIGNED_UNSIGNED_MULTIPLY_ADD, 3'h7, 3'h5, 3'h6, 1'b0, 16'h0000,
           40'hFF_A000_4000);
        op(OP_UNSIGNED_UNSIGNED_MULTIPLY_ADD, 3'h7, 3'h6, 3'h6, 1'b0, 16'h0000,
           40'h00_9FFE_4001);
    endtask : t_accumulate

    task automatic t_shifted();
        op(OP_SHIFT_ONE_MULTIPLY_ADD, 3'h0, 3'h1, 3'h2, 1'b0, 16'h0000,
           40'h01_1000_0000);
        op(OP_SHIFT_SIXTEEN_MULTIPLY_ADD, 3'h5, 3'h1, 3'h2, 1'b0, 16'h0000,
           40'h00_7FFF_C000);
        op(OP_SHIFT_SIXTEEN_MULTIPLY_ADD, 3'h5, 3'h6, 3'h2, 1'b0, 16'h0000,
           40'h00_0000_7FFF);
    endtask : t_shifted

    task automatic t_transfer();
        mv(3'h3, 3'h0, PART_HIGH);
        st(3'h0, PART_HIGH, 16'h1234);
        st(3'h0, PART_EXT, 16'h0001);
        mv(3'h3, 3'h6, PART_FULL);
        op(OP_OR, 3'h6, 3'h6, 3'h0, 1'b1, 16'h0000, 40'hA5_1234_ABCD);
    endtask : t_transfer

    task automatic t_back_to_back();
        @(posedge clk);
        put_op(OP_ADD, 3'h7, 3'h4, 3'h4, 1'b0, 16'h0000);
        @(posedge clk);
        put_op(OP_ADD, 3'h7, 3'h7, 3'h7, 1'b0, 16'h0000);
        #1;
        chk({res_valid, res_ovf32, res_data}, {2'h3, 40'h00_8000_0000});
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk({res_valid, res_ovf32, res_data}, {2'h3, 40'h01_0000_0000});
        @(posedge clk);
        #1;
        chk({res_valid, res_ovf32, res_data}, {2'h1, 40'h01_0000_0000});
    endtask : t_back_to_back

    // ---------------------------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #20000;
        mismatches++;
        wrap_up();
    end

    initial
    begin
        logic [15:0] words [8] = '{16'h1234, 16'hABCD, 16'h00A5, 16'h8000,
                                   16'h4000, 16'hC000, 16'h0003, 16'hFFFF};
        sys_rst <= 1'b1;
        {op_valid, op_use_imm} <= 2'h0;
        op_code <= OP_NOP;
        {op_dst, op_src_a, op_src_b} <= 9'h0;
        op_imm <= 16'h0000;
        {ld_valid, mv_valid, wr_en} <= 3'h0;
        {ld_reg, st_reg, mv_src, mv_dst, wr_addr, rd_addr} <= 18'h0;
        ld_part <= PART_LOW;
        st_part <= PART_LOW;
        mv_part <= PART_LOW;
        wr_data <= 16'h0000;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({res_valid, res_ovf32, res_data}, 42'h0);
        st(3'h0, PART_FULL, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            mem_put(i[2:0], words[i]);
        end
        t_parts();
        t_alu();
        t_multiply();
        t_accumulate();
        t_shifted();
        t_transfer();
        t_back_to_back();
        wrap_up();
    end
endmodule : tb_drfm_datapath
